// ### design/tofs_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the turn-off ramp and status summary files only
`ifndef TOFS_MAP_SVH
`define TOFS_MAP_SVH
`define TOFS_CMD_RAMP 8'h65
`define TOFS_CMD_SUMMARY 8'h78
`define TOFS_RAMP_RESET 7'h00
`define TOFS_SUMMARY_RESET 8'h41
`define TOFS_MANT_W 7
`define TOFS_BIT_OFF 6
`define TOFS_BIT_OVF 5
`define TOFS_BIT_OCF 4
`define TOFS_BIT_TEMP 2
`define TOFS_BIT_CML 1
`define TOFS_BIT_OTHER 0
`define TOFS_SRC_FAULT_BIT 7
`define TOFS_LOWVIN_BIT 3
`define TOFS_MS_PER_TICK 1
`define TOFS_CLK_KHZ 125000
`endif

// ### design/tofs_pkg.sv
// Types for the turn-off ramp and status summary block
// Assumes nothing beyond a SystemVerilog compiler
package tofs_pkg;
  typedef logic [7:0] tofs_cmd_t;
  typedef logic [15:0] tofs_word_t;
  typedef logic [6:0] tofs_ms_t;
  typedef enum logic [1:0] {tofs_idle_e, tofs_ack_e, tofs_nack_e} tofs_resp_e;
endpackage

// ### design/tofs_ramp_lut.sv
// Mantissa to effective ramp time in milliseconds
// Assumes a registered mantissa at its input
`include "tofs_map.svh"
module tofs_ramp_lut
  import tofs_pkg::*;
(
  input wire logic [`TOFS_MANT_W-1:0] mant,
  output tofs_pkg::tofs_ms_t ramp_ms
);
  // Bucket thresholds, zero folds into fastest ramp [RL2] [RL5]
  assign ramp_ms = (mant <= 7'd1) ? 7'd1 :
                   (mant <= 7'd6) ? mant :
                   (mant <= 7'd9) ? 7'd7 :
                   (mant <= 7'd12) ? 7'd10 :
                   (mant <= 7'd17) ? 7'd14 :
                   (mant <= 7'd22) ? 7'd19 :
                   (mant <= 7'd32) ? 7'd27 :
                   (mant <= 7'd44) ? 7'd37 :
                   (mant <= 7'd62) ? 7'd52 :
                   (mant <= 7'd86) ? 7'd72 : 7'd100;
endmodule

// ### design/tofs_regs.sv
// Turn-off ramp register and fault summary byte behind a PMBus command port
// Assumes a PMBus front end that presents decoded command strobes to clk_sys
//
// Notes on behaviour
// RL1: ramp value times fall; store-all saves it
// RL2: zero programs the fastest 1 ms ramp
// RL3: follower refuses ramp access, NACK, fault, alert
// RL4: exponent zero, upper mantissa zero, seven writable
// RL5: mantissa rounds into fifteen fixed ramp buckets
// RL6: summary byte layout, bits 7 and 3 zero
// RL7: output-off bit while converter not enabled
// RL8: overvoltage bit mirrors source; follower reads zero
// RL9: overcurrent bit mirrors source bit seven
// RL10: writes never clear summary bits
// RL11: temperature bit ORs temperature status
// RL12: comm bit ORs comm, memory, logic status
// RL13: other bit ORs remaining faults and warnings
// RL14: other bit resets to one via low input
`include "tofs_map.svh"
module tofs_regs
  import tofs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic loop_follower,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire tofs_pkg::tofs_cmd_t cmd_code,
  input wire tofs_pkg::tofs_word_t cmd_wdata,
  input wire logic store_all,
  input wire logic converter_enabled,
  input wire logic [7:0] status_vout,
  input wire logic [7:0] status_iout,
  input wire logic [7:0] status_temp,
  input wire logic [7:0] status_cml,
  input wire logic [7:0] status_input,
  input wire logic [7:0] status_mfr,
  output tofs_pkg::tofs_word_t rsp_rdata,
  output logic rsp_valid,
  output logic rsp_nack,
  output logic invalid_command_fault,
  output logic smbalert_req,
  output tofs_pkg::tofs_word_t nv_ramp_word,
  output logic nv_store,
  output tofs_pkg::tofs_ms_t ramp_ms
);
  import tofs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [`TOFS_MANT_W-1:0] mant;
  logic [7:0] summary;
  tofs_resp_e resp;
  tofs_ms_t next_ramp_ms;
  wire hit_ramp = cmd_valid && (cmd_code == `TOFS_CMD_RAMP);
  wire hit_sum = cmd_valid && (cmd_code == `TOFS_CMD_SUMMARY);
  wire ramp_refused = hit_ramp && loop_follower; // [RL3]
  wire ramp_wr = hit_ramp && cmd_write && !loop_follower;
  wire sum_rd = hit_sum && !cmd_write; // Writes to summary do nothing [RL10]

  // Read word assembly, ramp or summary
  wire [15:0] ramp_word = {9'h000, mant}; // [RL4]
  wire [15:0] rd_word = (hit_ramp) ? ramp_word : {8'h00, summary};
  wire any_hit = (hit_ramp && !loop_follower) || sum_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Summary sources
  wire src_ovf = status_vout[`TOFS_SRC_FAULT_BIT] && !loop_follower; // [RL8]
  wire src_ocf = status_iout[`TOFS_SRC_FAULT_BIT]; // [RL9]
  wire src_temp = |status_temp; // [RL11]
  wire src_cml = |status_cml; // [RL12]
  // Other: vout bits 6..2, iout warning, input, mfr [RL13]
  wire src_oth = (|status_vout[6:2]) || status_iout[5] || (|status_input) || (|status_mfr);
  // Byte assembly, reserved bits tied low
  wire [7:0] next_summary = {1'b0, !converter_enabled, src_ovf, src_ocf, 1'b0,
                             src_temp, src_cml, src_oth}; // [RL6] [RL7]

  // Bucket lookup of the stored mantissa
  tofs_ramp_lut u_lut (
    .mant(mant),
    .ramp_ms(next_ramp_ms)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ramp mantissa storage, only lower seven bits kept [RL1] [RL4]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mant <= `TOFS_RAMP_RESET;
    end else if (ramp_wr) begin
      mant <= cmd_wdata[`TOFS_MANT_W-1:0];
    end
  end

  // Summary mirror; reset shows low input pending [RL14]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      summary <= `TOFS_SUMMARY_RESET;
    end else begin
      summary <= next_summary;
    end
  end

  // Response state
  always_comb begin
    case ({ramp_refused, any_hit})
      2'b10: resp = tofs_nack_e;
      2'b01: resp = tofs_ack_e;
      default: resp = tofs_idle_e;
    endcase
  end

  // Answer, fault and alert pulses [RL3]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_rdata <= 16'h0000;
      invalid_command_fault <= 1'b0;
      smbalert_req <= 1'b0;
    end else begin
      rsp_valid <= (resp != tofs_idle_e);
      rsp_nack <= (resp == tofs_nack_e);
      rsp_rdata <= (resp == tofs_ack_e && !cmd_write) ? rd_word : 16'h0000;
      invalid_command_fault <= (resp == tofs_nack_e);
      smbalert_req <= (resp == tofs_nack_e);
    end
  end

  // Store-all snapshot and effective ramp time [RL1] [RL5]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nv_store <= 1'b0;
      nv_ramp_word <= 16'h0000;
      ramp_ms <= 7'd1;
    end else begin
      nv_store <= store_all;
      if (store_all) begin
        nv_ramp_word <= ramp_word;
      end
      ramp_ms <= next_ramp_ms;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Ramp access, refusal and bucket checks
  follower_nack_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
    ramp_refused |=> rsp_nack && invalid_command_fault && smbalert_req)
    else $error("follower ramp access not refused");
  follower_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
    ramp_refused && cmd_write |=> $stable(mant))
    else $error("follower write changed ramp");
  ramp_upper_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL4]
    rsp_rdata[15:7] == 9'h000)
    else $error("ramp upper bits not zero");
  ramp_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
    mant == 7'd0 |=> ramp_ms == 7'd1)
    else $error("zero ramp not 1 ms");
  ramp_top_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
    mant > 7'd86 |=> ramp_ms == 7'd100)
    else $error("top bucket wrong");
  ramp_mid_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
    mant == 7'd10 |=> ramp_ms == 7'd10)
    else $error("bucket ten wrong");

  // Summary mirror and store-all checks
  ovf_mirror_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
    1'b1 |=> summary[5] == ($past(status_vout[7]) && !$past(loop_follower)))
    else $error("overvoltage mirror wrong");
  ocf_mirror_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
    1'b1 |=> summary[4] == $past(status_iout[7]))
    else $error("overcurrent mirror wrong");
  off_bit_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
    !converter_enabled |=> summary[6])
    else $error("off bit missing");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
    !summary[7] && !summary[3])
    else $error("reserved summary bits set");
  temp_or_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL11]
    |status_temp |=> summary[2])
    else $error("temperature bit missing");
  cml_or_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL12]
    |status_cml |=> summary[1])
    else $error("comm bit missing");
  other_or_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL13]
    status_input[3] |=> summary[0])
    else $error("other bit missing");
  sum_write_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
    hit_sum && cmd_write && $stable(status_cml) |=> $stable(summary[1]))
    else $error("write cleared summary");
  store_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
    store_all |=> nv_store && nv_ramp_word == $past(ramp_word))
    else $error("store snapshot wrong");
  reset_other_a: assert property (@(posedge clk_sys) // [RL14]
    rst |=> summary == `TOFS_SUMMARY_RESET)
    else $error("summary reset wrong");
  // Answer, follower overvoltage and reset checks
  sum_ack_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
    sum_rd |=> rsp_valid && !rsp_nack && rsp_rdata == {8'h00, $past(summary)})
    else $error("summary read answer wrong");
  sum_nowr_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
    hit_sum && cmd_write |=> !rsp_valid)
    else $error("summary write answered");
  ramp_ack_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
    ramp_wr |=> rsp_valid && !rsp_nack && !invalid_command_fault && !smbalert_req)
    else $error("ramp write not acknowledged");
  ramp_rd_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL4]
    hit_ramp && !cmd_write && !loop_follower |=> rsp_rdata == {9'h000, $past(mant)})
    else $error("ramp read data wrong");
  follower_ovf_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
    loop_follower |=> !summary[5])
    else $error("follower overvoltage bit set");
  reset_ramp_a: assert property (@(posedge clk_sys) // [RL4]
    rst |=> ramp_ms == 7'd1 && mant == `TOFS_RAMP_RESET && !rsp_valid)
    else $error("ramp reset wrong");

  // Main scenarios
  ramp_rd_c: cover property (@(posedge clk_sys) hit_ramp && !cmd_write && !loop_follower);
  ramp_wr_c: cover property (@(posedge clk_sys) ramp_wr);
  follower_c: cover property (@(posedge clk_sys) ramp_refused);
  sum_rd_c: cover property (@(posedge clk_sys) sum_rd && summary[5]);
  sum_wr_c: cover property (@(posedge clk_sys) hit_sum && cmd_write);
endmodule

// ### test/tofs_host.sv
// PMBus host model: issues one decoded command access per call
// Assumes the bench samples answers right after access returns
module tofs_host
  import tofs_pkg::*;
(
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic cmd_write,
  output tofs_pkg::tofs_cmd_t cmd_code,
  output tofs_pkg::tofs_word_t cmd_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = '0;
  // One request pulse, returns while the answer stands; released data inverted
  task automatic access(input logic w, input tofs_cmd_t c, input tofs_word_t d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d;
    #1;
  endtask
endmodule

// ### test/turnoff_ramp_and_status_summary_tb.sv
// Bench for the turn-off ramp register and fault summary byte
// Assumes tofs_regs and the host model tofs_host
module turnoff_ramp_and_status_summary_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tofs_pkg::*;
  logic clk_sys = 0, rst = 1, follower = 0, store_all = 0, enabled = 0;
  logic [7:0] st [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
  logic [6:0] cor [10] = '{7'h00, 7'h01, 7'h02, 7'h06, 7'h07, 7'h09, 7'h0A, 7'h56, 7'h57, 7'h7F};
  logic [31:0] seed = 32'h0000005A;
  int n_fail = 0, n_tests = 0, cyc = 0;
  logic cmd_valid, cmd_write, rsp_valid, rsp_nack, inv_fault, alert, nv_store;
  tofs_cmd_t cmd_code;
  tofs_word_t cmd_wdata, rsp_rdata, nv_word;
  tofs_ms_t ramp_ms;
  tofs_regs u_tofs_regs (.clk_sys(clk_sys), .rst(rst), .loop_follower(follower),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .store_all(store_all), .converter_enabled(enabled), .status_vout(st[0]),
    .status_iout(st[1]), .status_temp(st[2]), .status_cml(st[3]), .status_input(st[4]),
    .status_mfr(st[5]), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
    .invalid_command_fault(inv_fault), .smbalert_req(alert), .nv_ramp_word(nv_word),
    .nv_store(nv_store), .ramp_ms(ramp_ms));
  tofs_host u_tofs_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  ////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bucketed ramp time
  function automatic int exp_ms(int m);
    int lim [9] = '{9, 12, 17, 22, 32, 44, 62, 86, 127};
    int ms [9] = '{7, 10, 14, 19, 27, 37, 52, 72, 100};
    if (m <= 1) return 1;
    if (m <= 6) return m;
    for (int i = 0; i < 9; i++) if (m <= lim[i]) return ms[i];
    return 100;
  endfunction
  function automatic logic [7:0] exp_sum();
    return {1'b0, !enabled, st[0][7] & !follower, st[1][7], 1'b0, |st[2], |st[3],
      |st[0][6:2] | st[1][5] | |st[4] | |st[5]};
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [6:0] m;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    u_tofs_host.access(1'b0, 8'h78, 16'h0000);
    chk("summary_reset", rsp_rdata, 16'h0041);
    chk("ramp_reset", 16'(ramp_ms), 16'h0001);
    for (int i = 0; i < 40; i++) begin
      r = nxt();
      m = (i < 10) ? cor[i] : r[6:0];
      u_tofs_host.access(1'b1, 8'h65, {r[24:16], m});
      chk("ramp_wr_ack", {12'h000, rsp_valid, rsp_nack, inv_fault, alert}, 16'h0008);
      @(posedge clk_sys);
      #1;
      chk("ramp_ms", 16'(ramp_ms), 16'(exp_ms(int'(m))));
      u_tofs_host.access(1'b0, 8'h65, 16'h0000);
      chk("ramp_rd", rsp_rdata, {9'h000, m});
    end
    @(posedge clk_sys);
    store_all <= 1'b1;
    @(posedge clk_sys);
    store_all <= 1'b0;
    #1;
    chk("nv_store", {nv_store, nv_word[14:0]}, {1'b1, 8'h00, m});
    @(posedge clk_sys);
    follower <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      u_tofs_host.access(k[0], 8'h65, {9'h000, ~m});
      chk("refuse", {12'h000, rsp_valid, rsp_nack, inv_fault, alert}, 16'h000F);
    end
    @(posedge clk_sys);
    follower <= 1'b0;
    u_tofs_host.access(1'b0, 8'h65, 16'h0000);
    chk("ramp_kept", rsp_rdata, {9'h000, m});
    for (int i = 0; i < 31; i++) begin
      @(posedge clk_sys);
      r = nxt();
      enabled <= r[0] | (i == 30);
      follower <= r[1] & (i < 30);
      for (int k = 0; k < 6; k++) begin
        r = nxt();
        st[k] <= (i == 30) ? 8'h00 : r[7:0] & r[15:8] & r[23:16];
      end
      u_tofs_host.access(1'b1, 8'h78, 16'hFFFF);
      chk("summary_wr", {15'h0000, rsp_valid}, 16'h0000);
      u_tofs_host.access(1'b0, 8'h78, 16'h0000);
      chk("summary", rsp_rdata, {8'h00, exp_sum()});
    end
    test_done();
  end
endmodule
